/* File: logic/udbg_bank.v */
// packet id, data buffer and configuration registers of the debug port
`timescale 1ns/100ps
`default_nettype none
`include "udbg_regs.vh"
module udbg_bank (
  // clock and combined register reset
  input wire core_clk,
  input wire clr,
  // software write port
  input wire sw_wr,
  input wire [7:0] sw_addr,
  input wire [31:0] sw_wdata,
  // engine side updates
  input wire eng_data_we,
  input wire [63:0] eng_data,
  input wire eng_pid_we,
  input wire [7:0] eng_pid,
  // read mux and register contents
  output reg [31:0] rd_value,
  output reg [63:0] data_ff,
  output reg [31:0] pid_ff,
  output reg [31:0] cfg_ff
);
  reg [63:0] nxt_data;
  reg [31:0] nxt_pid;
  reg [31:0] nxt_cfg;

  always @* begin
    nxt_data = data_ff;
    nxt_pid = pid_ff;
    nxt_cfg = cfg_ff;
    // engine data lands after the software write so a receive wins
    if (sw_wr && sw_addr == `UDBG_OFF_DLO) begin
      nxt_data[31:0] = sw_wdata;
    end
    if (sw_wr && sw_addr == `UDBG_OFF_DHI) begin
      nxt_data[63:32] = sw_wdata;
    end
    if (eng_data_we) begin
      nxt_data = eng_data;
    end
    // only the transmitted pid bits are writable by software
    if (sw_wr && sw_addr == `UDBG_OFF_PID) begin
      nxt_pid[`UDBG_PID_TX_HI:`UDBG_PID_TX_LO] =
        sw_wdata[`UDBG_PID_TX_HI:`UDBG_PID_TX_LO];
    end
    if (eng_pid_we) begin
      nxt_pid[`UDBG_PID_RX_HI:`UDBG_PID_RX_LO] = eng_pid;
    end
    if (sw_wr && sw_addr == `UDBG_OFF_CFG) begin
      nxt_cfg = sw_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (clr) begin
      data_ff <= {`UDBG_RST_DATA, `UDBG_RST_DATA};
      pid_ff <= `UDBG_RST_PID;
      cfg_ff <= `UDBG_RST_CFG;
    end else begin
      data_ff <= nxt_data;
      pid_ff <= nxt_pid;
      cfg_ff <= nxt_cfg;
    end
  end

  always @* begin
    case (sw_addr)
      `UDBG_OFF_PID: rd_value = pid_ff;
      `UDBG_OFF_DLO: rd_value = data_ff[31:0];
      `UDBG_OFF_DHI: rd_value = data_ff[63:32];
      `UDBG_OFF_CFG: rd_value = cfg_ff;
      default: rd_value = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

/* File: logic/udbg_ctrl.v */
// control/status front end of the usb debug port with its register map
// Function
// - block sits at offset a0h; config offset 5ah advertises that offset
// - structural params bits 23:20 report the debug root port number
// - decode five registers; configuration resets to 00007f01h, others zero
// - platform reset, controller soft reset and d3-to-d0 reset all registers
// - no checking of programming; illegal settings give undefined behaviour
// - ownership force bit 30 hands the port to the enhanced controller
// - ownership force overrides the standard ownership controls for this port
// - enable bit 28 clears when the port enable change flag would set
// - software may set enable only while the root port is enabled
// - software writing zero to enable clears it
// - completion flag bit 16 set by hardware, cleared by writing one
// - bits 15:12 read as fixed link id zero
// - bit 11 reads zero and ignores writes
// - writing one to trigger bit 5 starts a request; cleared at completion
// - byte count bits 3:0 hold 0..8; reads report received count
// - failure sets error flag and cause: 001 transaction, 010 port state
`timescale 1ns/100ps
`default_nettype none
`include "udbg_regs.vh"
module udbg_ctrl #(
  parameter [3:0] DEBUG_PORT_NUM = 4'h1
) (
  // clock and resets
  input wire core_clk,
  input wire rst,
  input wire controller_soft_reset,
  input wire d3_to_d0,
  // memory-mapped register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  output reg reg_rvalid_ff,
  // configuration space read port
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  output reg [15:0] cfg_rdata_ff,
  // structural parameters field
  output reg [3:0] structural_params_port_ff,
  // root port state and ownership
  input wire port_enabled,
  input wire port_enable_change_event,
  input wire port_suspended_or_reset,
  input wire std_owner_enhanced,
  output reg port_owner_enhanced_ff,
  output reg debug_port_enable_ff,
  // request engine
  output reg req_start_ff,
  output reg req_write_ff,
  output reg [3:0] req_byte_count_ff,
  input wire req_done,
  input wire req_error,
  input wire [2:0] req_cause,
  input wire [3:0] req_rx_count,
  input wire rx_data_we,
  input wire [63:0] rx_data,
  input wire rx_pid_we,
  input wire [7:0] rx_pid,
  output wire [63:0] buf_data,
  output wire [31:0] pid_value,
  output wire [31:0] cfg_value
);
  // request sequencing
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_FAIL = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg owner_ff, nxt_owner;
  reg nxt_enable;
  reg done_ff, nxt_done;
  reg inuse_ff, nxt_inuse;
  reg [2:0] cause_ff, nxt_cause;
  reg error_ff, nxt_error;
  reg trigger_ff, nxt_trigger;
  reg dir_ff, nxt_dir;
  reg [3:0] len_ff, nxt_len;
  reg nxt_start;
  reg [31:0] ctrl_value;
  reg [31:0] nxt_rdata;
  wire clr;
  wire ctrl_wr;
  wire go_wr;
  wire [31:0] bank_value;

  // every reset source returns the whole register set to defaults
  assign clr = rst | controller_soft_reset | d3_to_d0;
  assign ctrl_wr = reg_wr && reg_addr == `UDBG_OFF_CTRL;
  // a second go while the trigger bit is still set is ignored, so it cannot restart a busy request
  assign go_wr = ctrl_wr && reg_wdata[`UDBG_B_TRIGGER] &&
    !trigger_ff;

  always @* begin
    ctrl_value = 32'h00000000;
    ctrl_value[`UDBG_B_OWNER] = owner_ff;
    ctrl_value[`UDBG_B_ENABLE] = debug_port_enable_ff;
    ctrl_value[`UDBG_B_DONE] = done_ff;
    ctrl_value[`UDBG_F_LINK_HI:`UDBG_F_LINK_LO] = `UDBG_LINK_ID;
    ctrl_value[`UDBG_B_RSVD11] = 1'b0;
    ctrl_value[`UDBG_B_INUSE] = inuse_ff;
    ctrl_value[`UDBG_F_CAUSE_HI:`UDBG_F_CAUSE_LO] = cause_ff;
    ctrl_value[`UDBG_B_ERROR] = error_ff;
    ctrl_value[`UDBG_B_TRIGGER] = trigger_ff;
    ctrl_value[`UDBG_B_DIR] = dir_ff;
    ctrl_value[`UDBG_F_LEN_HI:`UDBG_F_LEN_LO] = len_ff;
  end

  always @* begin
    nxt_state = state_ff;
    nxt_owner = owner_ff;
    nxt_enable = debug_port_enable_ff;
    nxt_done = done_ff;
    nxt_inuse = inuse_ff;
    nxt_cause = cause_ff;
    nxt_error = error_ff;
    nxt_trigger = trigger_ff;
    nxt_dir = dir_ff;
    nxt_len = len_ff;
    nxt_start = 1'b0;
    if (ctrl_wr) begin
      nxt_owner = reg_wdata[`UDBG_B_OWNER];
      nxt_inuse = reg_wdata[`UDBG_B_INUSE];
      nxt_dir = reg_wdata[`UDBG_B_DIR];
      nxt_len = reg_wdata[`UDBG_F_LEN_HI:`UDBG_F_LEN_LO];
      if (!reg_wdata[`UDBG_B_ENABLE]) begin
        nxt_enable = 1'b0;
      end else if (port_enabled) begin
        nxt_enable = 1'b1;
      end
      // refused set leaves the bit at its current value
      if (reg_wdata[`UDBG_B_DONE]) begin
        nxt_done = 1'b0;
      end
    end
    // hardware clear wins over a software set in the same cycle
    if (port_enable_change_event) begin
      nxt_enable = 1'b0;
    end
    case (state_ff)
      ST_IDLE: begin
        if (go_wr) begin
          nxt_trigger = 1'b1;
          if (port_suspended_or_reset) begin
            nxt_state = ST_FAIL;
          end else begin
            nxt_start = 1'b1;
            nxt_state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (port_suspended_or_reset) begin
          nxt_state = ST_FAIL;
        end else if (req_done) begin
          nxt_done = 1'b1;
          nxt_trigger = 1'b0;
          nxt_error = req_error;
          nxt_cause = req_error ? req_cause : `UDBG_CAUSE_NONE;
          if (!dir_ff) begin
            nxt_len = (req_rx_count > `UDBG_LEN_MAX) ? `UDBG_LEN_MAX :
              req_rx_count;
          end
          nxt_state = ST_IDLE;
        end
      end
      ST_FAIL: begin
        // request met a suspended or resetting port
        nxt_done = 1'b1;
        nxt_trigger = 1'b0;
        nxt_error = 1'b1;
        nxt_cause = `UDBG_CAUSE_HW;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_trigger = 1'b0;
      end
    endcase
  end

  always @* begin
    if (reg_addr == `UDBG_OFF_CTRL) begin
      nxt_rdata = ctrl_value;
    end else begin
      nxt_rdata = bank_value;
    end
  end

  always @(posedge core_clk) begin
    if (clr) begin
      state_ff <= ST_IDLE;
      owner_ff <= 1'b0;
      debug_port_enable_ff <= 1'b0;
      done_ff <= 1'b0;
      inuse_ff <= 1'b0;
      cause_ff <= `UDBG_CAUSE_NONE;
      error_ff <= 1'b0;
      trigger_ff <= 1'b0;
      dir_ff <= 1'b0;
      len_ff <= 4'h0;
      req_start_ff <= 1'b0;
      req_write_ff <= 1'b0;
      req_byte_count_ff <= 4'h0;
      port_owner_enhanced_ff <= 1'b0;
      reg_rdata_ff <= 32'h00000000;
      reg_rvalid_ff <= 1'b0;
      cfg_rdata_ff <= 16'h0000;
      structural_params_port_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      owner_ff <= nxt_owner;
      debug_port_enable_ff <= nxt_enable;
      // a completion arriving with the clear still sets the flag
      done_ff <= nxt_done;
      inuse_ff <= nxt_inuse;
      cause_ff <= nxt_cause;
      error_ff <= nxt_error;
      trigger_ff <= nxt_trigger;
      dir_ff <= nxt_dir;
      len_ff <= nxt_len;
      req_start_ff <= nxt_start;
      req_write_ff <= nxt_dir;
      req_byte_count_ff <= nxt_len;
      // force overrides whatever the standard ownership controls say
      port_owner_enhanced_ff <= nxt_owner | std_owner_enhanced;
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
      if (cfg_rd) begin
        cfg_rdata_ff <= (cfg_addr == `UDBG_CFG_CAP_OFF) ?
          `UDBG_CAP_VALUE : 16'h0000;
      end
      structural_params_port_ff <= DEBUG_PORT_NUM;
    end
  end

  udbg_bank u_bank (
    .core_clk(core_clk),
    .clr(clr),
    .sw_wr(reg_wr),
    .sw_addr(reg_addr),
    .sw_wdata(reg_wdata),
    .eng_data_we(rx_data_we),
    .eng_data(rx_data),
    .eng_pid_we(rx_pid_we),
    .eng_pid(rx_pid),
    .rd_value(bank_value),
    .data_ff(buf_data),
    .pid_ff(pid_value),
    .cfg_ff(cfg_value)
  );
endmodule
`default_nettype wire

/* File: logic/udbg_regs.vh */
// register offsets, field positions and reset values of the debug port
`ifndef UDBG_REGS_VH
`define UDBG_REGS_VH

`define UDBG_OFF_CTRL 8'ha0
`define UDBG_OFF_PID 8'ha4
`define UDBG_OFF_DLO 8'ha8
`define UDBG_OFF_DHI 8'hac
`define UDBG_OFF_CFG 8'hb0

`define UDBG_CFG_CAP_OFF 8'h5a
`define UDBG_CAP_VALUE 16'h00a0

`define UDBG_RST_CTRL 32'h00000000
`define UDBG_RST_PID 32'h00000000
`define UDBG_RST_DATA 32'h00000000
`define UDBG_RST_CFG 32'h00007f01

`define UDBG_B_OWNER 30
`define UDBG_B_ENABLE 28
`define UDBG_B_DONE 16
`define UDBG_F_LINK_HI 15
`define UDBG_F_LINK_LO 12
`define UDBG_B_RSVD11 11
`define UDBG_B_INUSE 10
`define UDBG_F_CAUSE_HI 9
`define UDBG_F_CAUSE_LO 7
`define UDBG_B_ERROR 6
`define UDBG_B_TRIGGER 5
`define UDBG_B_DIR 4
`define UDBG_F_LEN_HI 3
`define UDBG_F_LEN_LO 0

`define UDBG_LINK_ID 4'h0
`define UDBG_CAUSE_NONE 3'h0
`define UDBG_CAUSE_XACT 3'h1
`define UDBG_CAUSE_HW 3'h2
`define UDBG_LEN_MAX 4'h8

`define UDBG_PID_TX_HI 15
`define UDBG_PID_TX_LO 0
`define UDBG_PID_RX_HI 23
`define UDBG_PID_RX_LO 16

`endif

/* File: verification/udbg_ctrl_monitor.sv */
// assertion checker for the debug port control front end
`timescale 1ns/100ps
`default_nettype none
module udbg_ctrl_monitor #(
  parameter [3:0] DEBUG_PORT_NUM = 4'h1
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic controller_soft_reset,
  input wire logic d3_to_d0,
  // register and config ports
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [15:0] cfg_rdata_ff,
  input wire logic [3:0] structural_params_port_ff,
  // port state and engine
  input wire logic port_enabled,
  input wire logic port_enable_change_event,
  input wire logic port_owner_enhanced_ff,
  input wire logic debug_port_enable_ff,
  input wire logic req_start_ff,
  input wire logic [31:0] cfg_value
);
  wire clr;
  wire ctl_wr;
  assign clr = rst | controller_soft_reset | d3_to_d0;
  assign ctl_wr = reg_wr && reg_addr == 8'ha0;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_cap;
    cfg_rd && cfg_addr == 8'h5a |=> cfg_rdata_ff == 16'h00a0;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability offset wrong");
  property p_port;
    !clr ##1 !clr |-> structural_params_port_ff == DEBUG_PORT_NUM;
  endproperty
  a_port: assert property (p_port)
    else $error("debug port number wrong");
  property p_rst;
    controller_soft_reset || d3_to_d0 |=> cfg_value == 32'h00007f01
      && !debug_port_enable_ff && !req_start_ff;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset source did not restore defaults");
  property p_own;
    ctl_wr && reg_wdata[30] |=> port_owner_enhanced_ff;
  endproperty
  a_own: assert property (p_own)
    else $error("ownership not forced");
  property p_evt;
    port_enable_change_event |=> !debug_port_enable_ff;
  endproperty
  a_evt: assert property (p_evt)
    else $error("enable survived change event");
  property p_refuse;
    ctl_wr && !port_enabled && !debug_port_enable_ff |=> !debug_port_enable_ff;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("enable set on disabled port");
  property p_off;
    ctl_wr && !reg_wdata[28] |=> !debug_port_enable_ff;
  endproperty
  a_off: assert property (p_off)
    else $error("enable not cleared by write");
  property p_rsvd;
    reg_rd && reg_addr == 8'ha0 |=> (reg_rdata_ff & 32'haffef800) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("fixed control bits read nonzero");
  property p_len;
    reg_rd && reg_addr == 8'ha0 |=> reg_rdata_ff[3:0] <= 4'h8;
  endproperty
  a_len: assert property (p_len)
    else $error("byte count above eight");
  property p_go;
    $rose(req_start_ff) |-> $past(reg_wr) && $past(reg_addr) == 8'ha0
      ##1 !req_start_ff;
  endproperty
  a_go: assert property (p_go)
    else $error("request start without trigger write");
endmodule
`default_nettype wire

/* File: verification/udbg_ctrl_tb.sv */
// self-checking bench for the debug port control front end
`timescale 1ns/100ps
`default_nettype none
module udbg_ctrl_tb;
  logic core_clk, rst, controller_soft_reset, d3_to_d0, reg_wr, reg_rd;
  logic cfg_rd, port_enabled, port_enable_change_event, rx_pid_we;
  logic port_suspended_or_reset, std_owner_enhanced, port_owner_enhanced_ff;
  logic reg_rvalid_ff, debug_port_enable_ff, req_start_ff, req_write_ff;
  logic req_done, req_error, rx_data_we, fail;
  logic [7:0] reg_addr, cfg_addr, rx_pid;
  logic [31:0] reg_wdata, reg_rdata_ff, pid_value, cfg_value;
  logic [15:0] cfg_rdata_ff;
  logic [3:0] structural_params_port_ff, req_byte_count_ff;
  logic [3:0] req_rx_count, lat, rx_cnt;
  logic [2:0] req_cause;
  logic [63:0] rx_data, buf_data;
  int fail_count = 0;
  int n_checks = 0;
  udbg_ctrl #(.DEBUG_PORT_NUM(4'h5)) i_udbg_ctrl (.*);
  udbg_engine_model i_udbg_engine_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    // idle edge so a following access never re-raises the strobe at once
    step();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid_ff}, 32'h1);
    chk(reg_rdata_ff, e);
    step();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  // go write, bounded wait for the engine, then one edge for done to land
  task automatic run(input logic [31:0] d, input logic [31:0] e);
    int n;
    wr(8'ha0, d);
    n = 0;
    while (req_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    step();
    rc(8'ha0, e);
    wr(8'ha0, 32'h00010000);
  endtask
  task automatic t_map();
    logic [7:0] a[6] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hc0};
    wr(8'hc0, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      rc(a[i], a[i] == 8'hb0 ? 32'h00007f01 : 32'h0);
    end
    wr(8'ha4, 32'hffffffff);
    rx_pid = 8'h4b;
    pulse(rx_pid_we);
    rc(8'ha4, 32'h004bffff);
    chk(pid_value, 32'h004bffff);
    pulse(cfg_rd);
    chk({16'h0, cfg_rdata_ff}, 32'h00a0);
    chk({28'h0, structural_params_port_ff}, 32'h5);
  endtask
  task automatic t_enable();
    wr(8'ha0, 32'h10000000);
    rc(8'ha0, 32'h0);
    port_enabled = 1'b1;
    wr(8'ha0, 32'h10000000);
    rc(8'ha0, 32'h10000000);
    wr(8'ha0, 32'h0);
    rc(8'ha0, 32'h0);
    wr(8'ha0, 32'h10000000);
    pulse(port_enable_change_event);
    rc(8'ha0, 32'h0);
    wr(8'ha0, 32'h4000fc00);
    step();
    chk({31'h0, port_owner_enhanced_ff}, 32'h1);
    rc(8'ha0, 32'h40000400);
  endtask
  task automatic t_requests();
    wr(8'ha0, 32'h00000018);
    chk({27'h0, req_write_ff, req_byte_count_ff}, 32'h18);
    run(32'h00000020, 32'h00010005);
    rc(8'ha8, 32'h04030201);
    rc(8'hac, 32'h08070605);
    chk(buf_data[63:32], 32'h08070605);
    rc(8'ha0, 32'h0);
    fail = 1'b1;
    run(32'h00000038, 32'h000100d8);
    port_suspended_or_reset = 1'b1;
    run(32'h00000020, 32'h00010140);
    port_suspended_or_reset = 1'b0;
  endtask
  task automatic t_resets();
    wr(8'hb0, 32'h0);
    pulse(controller_soft_reset);
    rc(8'hb0, 32'h00007f01);
    rc(8'ha0, 32'h0);
    chk(pid_value, 32'h0);
    wr(8'hb0, 32'h0);
    pulse(d3_to_d0);
    rc(8'hb0, 32'h00007f01);
    chk(cfg_value, 32'h00007f01);
  endtask
  initial begin
    {controller_soft_reset, d3_to_d0, reg_wr, reg_rd, cfg_rd} = '0;
    {port_enabled, port_enable_change_event, rx_pid_we, fail} = '0;
    {port_suspended_or_reset, std_owner_enhanced} = '0;
    {reg_addr, reg_wdata, rx_pid} = '0;
    cfg_addr = 8'h5a;
    lat = 4'h3;
    rx_cnt = 4'h5;
    rst = 1'b1;
    repeat (20) step();
    rst = 1'b0;
    t_map();
    t_enable();
    t_requests();
    t_resets();
    close_out();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
endmodule
bind udbg_ctrl udbg_ctrl_monitor #(.DEBUG_PORT_NUM(DEBUG_PORT_NUM))
  i_udbg_ctrl_monitor (
  .core_clk(core_clk),
  .rst(rst),
  .controller_soft_reset(controller_soft_reset),
  .d3_to_d0(d3_to_d0),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff),
  .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr),
  .cfg_rdata_ff(cfg_rdata_ff),
  .structural_params_port_ff(structural_params_port_ff),
  .port_enabled(port_enabled),
  .port_enable_change_event(port_enable_change_event),
  .port_owner_enhanced_ff(port_owner_enhanced_ff),
  .debug_port_enable_ff(debug_port_enable_ff),
  .req_start_ff(req_start_ff),
  .cfg_value(cfg_value)
);
`default_nettype wire

/* File: verification/udbg_engine_model.sv */
// behavioural request engine standing for the console side
`timescale 1ns/100ps
`default_nettype none
module udbg_engine_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from the block
  input wire logic req_start_ff,
  input wire logic req_write_ff,
  // answer shaping from the bench
  input wire logic [3:0] lat,
  input wire logic fail,
  input wire logic [3:0] rx_cnt,
  // answer to the block
  output logic req_done,
  output logic req_error,
  output logic [2:0] req_cause,
  output logic [3:0] req_rx_count,
  output logic rx_data_we,
  output logic [63:0] rx_data
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  always @(posedge core_clk) begin
    req_done <= 1'b0;
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (req_start_ff) begin
      busy_ff <= 1'b1;
      cnt_ff <= lat;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff <= 1'b0;
      req_done <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  // fields are scrambled outside done so stale values cannot pass
  assign req_error = req_done ? fail : ~fail;
  assign req_cause = req_done ? {2'h0, fail} : 3'h6;
  assign req_rx_count = req_done ? rx_cnt : ~rx_cnt;
  assign rx_data_we = req_done & ~req_write_ff;
  assign rx_data = {64{~req_done}} ^ 64'h0807060504030201;
endmodule
`default_nettype wire
